//--- rtl/cwd_pkg.sv
// package: register offsets, field positions, window map and carrier structs
package cwd_pkg;
    localparam logic [7:0] OFS_WINDOW_BASE = 8'h48;
    localparam logic [7:0] OFS_MISC_CTRL = 8'h50;
    localparam logic [31:0] RST_WINDOW_BASE = 32'h0000_0000;
    localparam logic [15:0] RST_MISC_CTRL = 16'h0000;
    localparam int BIT_MONO_PRESENT = 0;
    localparam int BIT_WINDOW_EN = 8;
    localparam int BIT_APERTURE_EN = 9;
    localparam logic [15:0] MISC_CTRL_MASK = 16'h0301;
    // window sub-ranges, compared on offset bits 15:8 (compensation range on bits 15:12)
    localparam logic [7:0] SUB_D0F0 = 8'h00;
    localparam logic [7:0] SUB_D0F1 = 8'h01;
    localparam logic [7:0] SUB_D0F3 = 8'h03;
    localparam logic [7:0] SUB_D1F0 = 8'h08;
    localparam logic [7:0] SUB_D2F0 = 8'h10;
    localparam logic [7:0] SUB_D2F1 = 8'h11;
    localparam logic [3:0] SUB_COMP = 4'h8;
    // legacy monochrome and VGA resources
    localparam logic [31:0] MONO_MEM_LO = 32'h000B_0000;
    localparam logic [31:0] MONO_MEM_HI = 32'h000B_7FFF;
    localparam logic [31:0] VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [9:0] IO_3B0 = 10'h3B0;
    localparam logic [9:0] IO_3BC = 10'h3BC;
    localparam logic [9:0] IO_3BF = 10'h3BF;
    localparam logic [9:0] IO_3C0 = 10'h3C0;
    localparam logic [9:0] IO_3DF = 10'h3DF;
    // one bit per port 3B0-3BF: 3B4, 3B5, 3B8, 3B9, 3BA and 3BF
    localparam logic [15:0] MONO_IO_MAP = 16'h8730;

    typedef enum logic [2:0] {
        CWD_TGT_NONE,
        CWD_TGT_CFG,
        CWD_TGT_COMP,
        CWD_TGT_RSVD
    } cwd_target_e;

    typedef enum logic [1:0] {
        CWD_ROUTE_NORMAL,
        CWD_ROUTE_HUB,
        CWD_ROUTE_PCI
    } cwd_route_e;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic write;
        logic [31:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cwd_req_s;

    typedef struct packed {
        logic claim;
        cwd_target_e target;
        logic [2:0] dev;
        logic [2:0] func;
        logic [11:0] offset;
        logic write;
        logic [31:0] wdata;
    } cwd_alias_s;
endpackage : cwd_pkg

//--- rtl/cwd_legacy_route.sv
// legacy monochrome / VGA reference router
module cwd_legacy_route
    import cwd_pkg::*;
(
    input wire logic is_io,
    input wire logic [31:0] addr,
    input wire logic [3:0] byte_en,
    input wire logic vga_enable,
    input wire logic mono_present,
    output cwd_route_e route
);
    logic [9:0] io_base;
    logic [3:0] mono_hit_b;
    logic [3:0] vga_hit_b;
    logic [3:0] only_3bf_b;
    logic mono_hit;
    logic vga_hit;
    logic mono_only_hit;
    logic mem_mono;
    logic mem_vga;

    // bits 15:10 ignored, so every alias decodes the same
    assign io_base = {addr[9:2], 2'b00};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            logic [9:0] a;
            assign a = io_base | 10'(gi);
            assign mono_hit_b[gi] = byte_en[gi] && a >= IO_3B0 && a <= IO_3BF && MONO_IO_MAP[a[3:0]];
            assign only_3bf_b[gi] = byte_en[gi] && a == IO_3BF;
            assign vga_hit_b[gi] = byte_en[gi] && ((a >= IO_3B0 && a < IO_3BC) || (a >= IO_3C0 && a <= IO_3DF));
        end
    endgenerate

    assign mono_hit = is_io && (|mono_hit_b);
    assign mono_only_hit = is_io && (|only_3bf_b);
    assign vga_hit = is_io && (|vga_hit_b);
    assign mem_mono = !is_io && addr >= MONO_MEM_LO && addr <= MONO_MEM_HI;
    assign mem_vga = !is_io && addr >= VGA_MEM_LO && addr <= VGA_MEM_HI;

    always_comb begin
        route = CWD_ROUTE_NORMAL;
        if (!vga_enable) begin
            // 3BC-3BE treated as ordinary I/O when VGA is off; 3BF still goes to the hub
            if (mono_hit || mono_only_hit || vga_hit || mem_vga) begin
                route = CWD_ROUTE_HUB;
            end
        end else if (mono_present) begin
            if (mono_hit || mono_only_hit || mem_mono) begin
                route = CWD_ROUTE_HUB;
            end else if (vga_hit || mem_vga) begin
                route = CWD_ROUTE_PCI;
            end
        end else begin
            if (mono_only_hit) begin
                route = CWD_ROUTE_HUB;
            end else if (mono_hit || vga_hit || mem_vga) begin
                route = CWD_ROUTE_PCI;
            end
        end
        if (is_io && vga_enable && (|(byte_en & {4{io_base[9:2] == IO_3BC[9:2]}}))) begin
            route = CWD_ROUTE_HUB;
        end
    end
endmodule : cwd_legacy_route

//--- rtl/cwd_config_window.sv
// register window base, misc control and host cycle decode
// Notes on behaviour
// - window base claims one naturally aligned 64 KB memory block
// - base bits 31:16 writable and compared with address 31:16; low half reserved
// - offsets 0000, 0100, 0300 pages alias device 0 functions 0, 1, 3
// - offsets 0800, 1000, 1100 pages alias device 1 f0, device 2 f0/f1
// - offsets 8000-8FFF decode to the compensation register range
// - window decoded only while control bit 8 is set
// - control bit 9 clear blocks graphics aperture accesses from all ports
// - with digital video strap, aperture enable is read-only
// - VGA enable set sends I/O 3BC-3BF to the hub link
// - mono resources: memory B0000-B7FFF, six I/O ports, aliases included (bits 15:10 ignored)
// - with mono set, any I/O reference touching a mono location goes to the hub
// - VGA and mono both clear: all legacy references to the hub
// - VGA only: VGA to PCI, 3BF and aliases to the hub
// - VGA and mono set: VGA to PCI, all mono to the hub
module cwd_config_window
    import cwd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    // configuration space port of device 0 function 0
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // host cycles
    input cwd_req_s host_req,
    input wire logic vga_enable,
    input wire logic digital_video_output_mode,
    input wire logic aperture_hit,
    output logic window_claim,
    output logic [31:0] window_rdata,
    output logic window_rvalid,
    // aliased accesses toward internal config and compensation spaces
    output cwd_alias_s alias_req,
    input wire logic [31:0] alias_rdata,
    // legacy routing and aperture gate
    output cwd_route_e legacy_route,
    output logic aperture_allow,
    output logic [15:0] misc_bridge_control
);
    typedef struct packed {
        logic [15:0] base_hi;
        logic [15:0] misc;
        logic [31:0] cfg_rdata;
        cwd_alias_s alias_q;
        logic rd_pending;
        logic rd_rsvd;
        logic [31:0] win_rdata;
        logic win_rvalid;
    } cwd_state_s;

    cwd_state_s st;
    cwd_state_s next_st;

    logic win_hit;
    logic [15:0] win_ofs;
    logic [7:0] page;
    cwd_target_e tgt;
    logic [2:0] dev;
    logic [2:0] func;
    logic [15:0] misc_wmask;
    logic [15:0] wr16;

    // ---------------------------------------------------------------
    // window decode
    // ---------------------------------------------------------------
    assign win_ofs = host_req.addr[15:0];
    assign page = win_ofs[15:8];
    assign win_hit = host_req.valid && !host_req.is_io
        && host_req.addr[31:16] == st.base_hi
        && st.misc[BIT_WINDOW_EN];

    always_comb begin
        tgt = CWD_TGT_RSVD;
        dev = 3'h0;
        func = 3'h0;
        unique case (page)
            SUB_D0F0: begin tgt = CWD_TGT_CFG; end
            SUB_D0F1: begin tgt = CWD_TGT_CFG; func = 3'h1; end
            SUB_D0F3: begin tgt = CWD_TGT_CFG; func = 3'h3; end
            SUB_D1F0: begin tgt = CWD_TGT_CFG; dev = 3'h1; end
            SUB_D2F0: begin tgt = CWD_TGT_CFG; dev = 3'h2; end
            SUB_D2F1: begin tgt = CWD_TGT_CFG; dev = 3'h2; func = 3'h1; end
            default: begin
                if (page[7:4] == SUB_COMP) begin
                    tgt = CWD_TGT_COMP;
                end
            end
        endcase
    end

    // aperture enable frozen while the strap picks digital video
    always_comb begin
        misc_wmask = MISC_CTRL_MASK;
        if (digital_video_output_mode) begin
            misc_wmask[BIT_APERTURE_EN] = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.alias_q.claim = 1'b0;
        next_st.win_rvalid = 1'b0;
        next_st.rd_pending = 1'b0;
        wr16 = 16'h0000;
        // configuration space writes, byte lanes honoured
        if (cfg_valid && cfg_write) begin
            if (cfg_offset == OFS_WINDOW_BASE) begin
                if (cfg_byte_en[2]) next_st.base_hi[7:0] = cfg_wdata[23:16];
                if (cfg_byte_en[3]) next_st.base_hi[15:8] = cfg_wdata[31:24];
            end else if (cfg_offset == OFS_MISC_CTRL) begin
                wr16 = st.misc;
                if (cfg_byte_en[0]) wr16[7:0] = cfg_wdata[7:0];
                if (cfg_byte_en[1]) wr16[15:8] = cfg_wdata[15:8];
                next_st.misc = (st.misc & ~misc_wmask) | (wr16 & misc_wmask);
            end
        end
        // configuration space reads
        if (cfg_valid && !cfg_write) begin
            unique case (cfg_offset)
                OFS_WINDOW_BASE: next_st.cfg_rdata = {st.base_hi, 16'h0000};
                OFS_MISC_CTRL: next_st.cfg_rdata = {16'h0000, st.misc};
                default: next_st.cfg_rdata = 32'h0000_0000;
            endcase
        end
        // window cycles: aligned dword access assumed from the host
        if (win_hit) begin
            if (tgt == CWD_TGT_RSVD) begin
                if (!host_req.write) begin
                    next_st.rd_pending = 1'b1;
                    next_st.rd_rsvd = 1'b1;
                end
            end else begin
                next_st.alias_q.claim = 1'b1;
                next_st.alias_q.target = tgt;
                next_st.alias_q.dev = dev;
                next_st.alias_q.func = func;
                // config pages carry only the 256-byte register offset
                next_st.alias_q.offset = (tgt == CWD_TGT_COMP) ? {win_ofs[11:2], 2'b00}
                    : {4'h0, win_ofs[7:2], 2'b00};
                next_st.alias_q.write = host_req.write;
                next_st.alias_q.wdata = host_req.wdata;
                next_st.rd_pending = !host_req.write;
                next_st.rd_rsvd = 1'b0;
            end
        end
        // read answer one cycle after the alias request
        if (st.rd_pending) begin
            next_st.win_rvalid = 1'b1;
            next_st.win_rdata = st.rd_rsvd ? 32'h0000_0000 : alias_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.base_hi <= RST_WINDOW_BASE[31:16];
            st.misc <= RST_MISC_CTRL;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    cwd_legacy_route u_route (
        .is_io(host_req.is_io),
        .addr(host_req.addr),
        .byte_en(host_req.byte_en),
        .vga_enable(vga_enable),
        .mono_present(st.misc[BIT_MONO_PRESENT]),
        .route(legacy_route)
    );

    assign window_claim = win_hit;
    assign aperture_allow = aperture_hit && st.misc[BIT_APERTURE_EN];
    assign alias_req = st.alias_q;
    assign window_rdata = st.win_rdata;
    assign window_rvalid = st.win_rvalid;
    assign cfg_rdata = st.cfg_rdata;
    assign misc_bridge_control = st.misc;
endmodule : cwd_config_window

//--- bench/cwd_cfg_target.sv
// partner: internal config and compensation target answering aliased reads
module cwd_cfg_target
    import cwd_pkg::*;
(
    input cwd_alias_s alias_req,
    output logic [31:0] alias_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [31:0] pat = (alias_req.target == CWD_TGT_COMP) ? {20'hC0C0C, alias_req.offset} :
        {alias_req.dev, alias_req.func, 14'h2AAA, alias_req.offset};
    // idle bus shows the inverted pattern so stale data never matches
    assign alias_rdata = alias_req.claim ? pat : ~pat;
endmodule : cwd_cfg_target

//--- bench/cwd_config_window_checker.sv
// checker: window decode, alias timing and legacy routing properties
module cwd_config_window_checker
    import cwd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input cwd_req_s host_req,
    input wire logic vga_enable,
    input wire logic digital_video_output_mode,
    input wire logic aperture_hit,
    input logic window_claim,
    input logic [31:0] window_rdata,
    input logic window_rvalid,
    input cwd_alias_s alias_req,
    input wire logic [31:0] alias_rdata,
    input cwd_route_e legacy_route,
    input logic aperture_allow,
    input logic [15:0] misc_bridge_control
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic [7:0] pg = host_req.addr[15:8];
    wire logic mapped = (pg inside {SUB_D0F0, SUB_D0F1, SUB_D0F3, SUB_D1F0, SUB_D2F0, SUB_D2F1}) || pg[7:4] == SUB_COMP;
    win_gate_a: assert property (window_claim |-> host_req.valid && !host_req.is_io &&
        misc_bridge_control[BIT_WINDOW_EN]) else $error("window claimed while disabled");
    alias_d0_a: assert property (window_claim && pg == SUB_D0F0 |=> alias_req.claim &&
        alias_req.dev == 3'h0 && alias_req.func == 3'h0) else $error("page 00 alias wrong");
    alias_d2_a: assert property (window_claim && pg == SUB_D2F1 |=> alias_req.claim &&
        alias_req.target == CWD_TGT_CFG && alias_req.dev == 3'h2 && alias_req.func == 3'h1) else $error("page 11 alias wrong");
    alias_comp_a: assert property (window_claim && pg[7:4] == SUB_COMP |=>
        alias_req.claim && alias_req.target == CWD_TGT_COMP) else $error("compensation alias wrong");
    rsvd_quiet_a: assert property (window_claim && !mapped |=> !alias_req.claim)
        else $error("reserved page aliased");
    rsvd_read_a: assert property (window_claim && !mapped && !host_req.write |-> ##2
        (window_rvalid && window_rdata == 32'h0)) else $error("reserved read not zero");
    read_data_a: assert property (alias_req.claim && !alias_req.write |=> window_rvalid &&
        window_rdata == $past(alias_rdata)) else $error("window read data wrong");
    aperture_a: assert property (aperture_allow == (aperture_hit &&
        misc_bridge_control[BIT_APERTURE_EN])) else $error("aperture gate wrong");
    strap_hold_a: assert property (digital_video_output_mode |=>
        $stable(misc_bridge_control[BIT_APERTURE_EN])) else $error("aperture bit changed under strap");
    legacy_hub_a: assert property (vga_enable && host_req.valid && host_req.is_io &&
        host_req.addr[9:2] == IO_3BC[9:2] |-> legacy_route == CWD_ROUTE_HUB) else $error("3BC-3BF not to hub");
    cover property (window_claim && mapped);
    cover property (window_rvalid);
    cover property (legacy_route == CWD_ROUTE_PCI);
    cover property (window_claim && !mapped && !host_req.write);
endmodule : cwd_config_window_checker
bind cwd_config_window cwd_config_window_checker u_chk (.sys_clk, .rst_b, .host_req, .vga_enable,
    .digital_video_output_mode, .aperture_hit, .window_claim, .window_rdata, .window_rvalid, .alias_req,
    .alias_rdata, .legacy_route, .aperture_allow, .misc_bridge_control);

//--- bench/cwd_config_window_tb_top.sv
// testbench: register access, window decode and legacy routing
module cwd_config_window_tb_top
    import cwd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic io;
        logic [31:0] a;
        logic [3:0] be;
        logic vga;
        logic mono;
        cwd_route_e r;
    } cwd_row_s;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cfg_valid = 1'b0;
    logic cfg_write = 1'b0;
    logic [7:0] cfg_offset = 8'h00;
    logic [3:0] cfg_byte_en = 4'hF;
    logic [31:0] cfg_wdata = 32'h0;
    cwd_req_s host_req = '0;
    logic vga_enable = 1'b0;
    logic digital_video_output_mode = 1'b0;
    logic aperture_hit = 1'b0;
    logic [31:0] cfg_rdata, window_rdata, alias_rdata;
    logic window_claim, window_rvalid, aperture_allow;
    logic [15:0] misc_bridge_control;
    cwd_alias_s alias_req;
    cwd_route_e legacy_route;
    int errors = 0;
    int tests_run = 0;
    cwd_row_s rows [14] = '{
        '{1'b1, 32'h3BC, 4'h1, 1'b0, 1'b0, CWD_ROUTE_NORMAL},
        '{1'b1, 32'h3B4, 4'h1, 1'b0, 1'b0, CWD_ROUTE_HUB}, '{1'b0, 32'hB8000, 4'hF, 1'b0, 1'b0, CWD_ROUTE_HUB},
        '{1'b1, 32'h3BC, 4'h8, 1'b1, 1'b0, CWD_ROUTE_HUB}, '{1'b1, 32'h3BC, 4'h1, 1'b1, 1'b0, CWD_ROUTE_HUB},
        '{1'b1, 32'h3B4, 4'h1, 1'b1, 1'b0, CWD_ROUTE_PCI}, '{1'b0, 32'hB0000, 4'hF, 1'b1, 1'b0, CWD_ROUTE_PCI},
        '{1'b1, 32'hFFB4, 4'h1, 1'b1, 1'b1, CWD_ROUTE_HUB}, '{1'b1, 32'h3B4, 4'hE, 1'b1, 1'b1, CWD_ROUTE_HUB},
        '{1'b1, 32'h3B4, 4'hC, 1'b1, 1'b1, CWD_ROUTE_PCI}, '{1'b0, 32'hB0000, 4'hF, 1'b1, 1'b1, CWD_ROUTE_HUB},
        '{1'b0, 32'hA0000, 4'hF, 1'b1, 1'b1, CWD_ROUTE_PCI}, '{1'b1, 32'h80, 4'hF, 1'b1, 1'b1, CWD_ROUTE_NORMAL},
        '{1'b1, 32'h3B8, 4'h8, 1'b1, 1'b1, CWD_ROUTE_PCI}};
    logic [15:0] pg [10] = '{16'h0044, 16'h0144, 16'h0344, 16'h0844, 16'h1004, 16'h11FC, 16'h8FFC,
        16'h0200, 16'h0400, 16'h9000};
    cwd_target_e tg [10] = '{CWD_TGT_CFG, CWD_TGT_CFG, CWD_TGT_CFG, CWD_TGT_CFG, CWD_TGT_CFG, CWD_TGT_CFG,
        CWD_TGT_COMP, CWD_TGT_RSVD, CWD_TGT_RSVD, CWD_TGT_RSVD};
    logic [5:0] df [10] = '{6'h00, 6'h01, 6'h03, 6'h08, 6'h10, 6'h11, 6'h00, 6'h00, 6'h00, 6'h00};

    cwd_config_window DUT (.sys_clk, .rst_b, .cfg_valid, .cfg_write, .cfg_offset, .cfg_byte_en, .cfg_wdata,
        .cfg_rdata, .host_req, .vga_enable, .digital_video_output_mode, .aperture_hit, .window_claim,
        .window_rdata, .window_rvalid, .alias_req, .alias_rdata, .legacy_route, .aperture_allow,
        .misc_bridge_control);
    cwd_cfg_target u_tgt (.alias_req, .alias_rdata);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cfg(input logic wr, input logic [7:0] o, input logic [31:0] d);
        @(negedge sys_clk);
        cfg_valid = 1'b1;
        cfg_write = wr;
        cfg_offset = o;
        cfg_wdata = d;
        @(negedge sys_clk);
        cfg_valid = 1'b0;
    endtask : cfg

    task automatic rd(input logic [7:0] o, input logic [31:0] e);
        cfg(1'b0, o, 32'h0);
        chk("cfg_rdata", e, cfg_rdata);
    endtask : rd

    task automatic win(input logic [31:0] a, input logic c, input int i);
        logic [11:0] ofs;
        ofs = (tg[i] == CWD_TGT_COMP) ? a[11:0] : {4'h0, a[7:0]};
        @(negedge sys_clk);
        host_req = '{1'b1, 1'b0, 1'b0, a, 4'hF, 32'h0};
        #1 chk("window_claim", 32'(c), 32'(window_claim));
        @(negedge sys_clk);
        host_req.valid = 1'b0;
        if (c) begin
            chk("alias_claim", 32'(tg[i] != CWD_TGT_RSVD), 32'(alias_req.claim));
            @(negedge sys_clk);
            chk("window_rdata", (tg[i] == CWD_TGT_RSVD) ? 32'h0 : (tg[i] == CWD_TGT_COMP) ?
                {20'hC0C0C, ofs} : {df[i][5:3], df[i][2:0], 14'h2AAA, ofs}, window_rdata);
            chk("window_rvalid", 32'h1, 32'(window_rvalid));
        end
    endtask : win

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            cfg(1'b1, OFS_MISC_CTRL, 32'(rows[i].mono));
            vga_enable = rows[i].vga;
            host_req = '{1'b1, rows[i].io, 1'b0, rows[i].a, rows[i].be, 32'h0};
            #1 chk("legacy_route", 32'(rows[i].r), 32'(legacy_route));
            @(negedge sys_clk);
            host_req.valid = 1'b0;
        end
        $display("legacy routing done");
        cfg(1'b1, OFS_WINDOW_BASE, 32'h1234_0000);
        @(negedge sys_clk);
        rst_b = 1'b0;
        @(negedge sys_clk);
        rst_b = 1'b1;
        aperture_hit = 1'b1;
        rd(OFS_WINDOW_BASE, RST_WINDOW_BASE);
        rd(OFS_MISC_CTRL, 32'(RST_MISC_CTRL));
        chk("aperture_allow", 32'h0, 32'(aperture_allow));
        $display("reset done");
        cfg(1'b1, OFS_WINDOW_BASE, 32'hFFFF_FFFF);
        rd(OFS_WINDOW_BASE, 32'hFFFF_0000);
        cfg(1'b1, OFS_MISC_CTRL, 32'hFFFF_FFFF);
        rd(OFS_MISC_CTRL, 32'(MISC_CTRL_MASK));
        chk("aperture_allow", 32'h1, 32'(aperture_allow));
        digital_video_output_mode = 1'b1;
        cfg(1'b1, OFS_MISC_CTRL, 32'h0);
        rd(OFS_MISC_CTRL, 32'h0200);
        digital_video_output_mode = 1'b0;
        $display("register access done");
        cfg(1'b1, OFS_MISC_CTRL, 32'h0);
        cfg(1'b1, OFS_WINDOW_BASE, 32'h1234_0000);
        win(32'h1234_1004, 1'b0, 4);
        cfg(1'b1, OFS_MISC_CTRL, 32'h0100);
        rd(OFS_MISC_CTRL, 32'h0100);
        foreach (pg[i]) win({16'h1234, pg[i]}, 1'b1, i);
        @(negedge sys_clk);
        host_req = '{1'b1, 1'b0, 1'b1, 32'h1234_1008, 4'hF, 32'hCAFE_0123};
        @(negedge sys_clk);
        host_req = '{1'b1, 1'b0, 1'b1, 32'h1234_0208, 4'hF, 32'h5555_AAAA};
        chk("alias_write", 32'h1, 32'(alias_req.claim && alias_req.write));
        chk("alias_wdata", 32'hCAFE_0123, alias_req.wdata);
        chk("alias_offset", 32'h008, 32'(alias_req.offset));
        @(negedge sys_clk);
        host_req.valid = 1'b0;
        chk("rsvd_write_claim", 32'h0, 32'(alias_req.claim));
        chk("write_rvalid", 32'h0, 32'(window_rvalid));
        @(negedge sys_clk);
        chk("rsvd_write_rvalid", 32'h0, 32'(window_rvalid));
        win(32'h1235_1004, 1'b0, 4);
        $display("window decode done");
        end_sim();
    end
endmodule : cwd_config_window_tb_top
